// ### hdl/esc_classifier.sv
// Error severity classifier: correction, exception request and severity syndrome
//
// How it works
// - Correctable or deferrable errors are fixed, logged, and raise a fault interrupt.
// - Uncorrected external aborts on read, write or cache maintenance raise an exception.
// - Aborts from speculation or prefetch only are delivered as asynchronous SError.
// - Consumed means corrupt commit, committed faulty fetch, or walk for committed access.
// - Every consumed uncorrected error gives an exception or enters failure mode.
// - Possibly silently propagated errors are classed uncontainable unless the spread is contained.
// - Not propagated but infected or imprecise errors are classed unrecoverable.
// - Unconsumed precise errors needing software repair are classed recoverable.
// - Unconsumed precise errors needing no repair are classed restartable.
// - Taking an error exception writes severity and state class into the syndrome.
// - Reported severity may be raised above true class but never lowered.
// - Propagation stays contained only in data registers after exception or barrier.
// - Non-architectural internal errors arrive as recovery interrupts from nodes.
// - Software reaches the local error nodes through a system register port.
// - Undetermined containability is classed uncontainable.
`timescale 1ns/100ps
module esc_classifier
    import esc_pkg::*;
(
    input  wire logic                 core_clk,       // Core clock, 100 MHz
    input  wire logic                 rst,            // Synchronous reset, active high
    input  wire logic                 errValid,       // Error detected this cycle
    input  wire logic                 errCorrectable, // Hardware can correct or defer it
    input  wire logic                 errAbort,       // Signalled as external abort
    input  wire logic [1:0]           errSrc,         // Access kind, esc_src_e
    input  wire logic                 errSpecOnly,    // Consumed only by speculation
    input  wire logic                 commitCorrupt,  // Instruction commits corrupt data
    input  wire logic                 commitFetch,    // Faulty fetch committed
    input  wire logic                 commitWalk,     // Walk error serves committed access
    input  wire logic                 silentProp,     // May have been silently propagated
    input  wire logic                 containedProp,  // Propagation in data regs after sync
    input  wire logic                 containKnown,   // Containability determined
    input  wire logic                 imprecise,      // Exception would be imprecise
    input  wire logic                 needsRepair,    // Resume needs software repair
    input  wire logic                 canException,   // Exception path available
    input  wire logic                 raiseFloor,     // Report one class more severe
    input  wire logic [NODE_COUNT-1:0] nodeIrq,       // Recovery interrupts, async
    input  wire logic                 sysRegRead,     // System register read strobe
    input  wire logic [NODE_W-1:0]    sysRegSel,      // Node index selected
    output logic                      fixIrq,         // Fault handling interrupt pulse
    output logic                      excReq,         // Synchronous error exception pulse
    output logic                      serrReq,        // SError interrupt pulse
    output logic [1:0]                excClass,       // Severity, esc_class_e
    output logic [3:0]                excClassOneHot, // Severity one-hot
    output logic [SYN_W-1:0]          syndrome,       // Last syndrome taken
    output logic                      failMode,       // Failure mode entered, sticky
    output logic                      logValid,       // Corrected error logged pulse
    output logic [1:0]                logSrc,         // Source of logged error
    output logic                      recoveryIrq,    // Any node interrupt pending
    output logic                      sysRegValid,    // System register read answer
    output logic                      sysRegData      // Selected node status
);

    logic                  consumed;
    logic                  uncorrected;
    logic                  needAct;
    logic                  trulyUncontained;
    esc_class_e            trueClass;
    esc_class_e            next_class;
    esc_state_e            next_state;
    logic [NODE_COUNT-1:0] nodeSync;

    assign consumed    = commitCorrupt | commitFetch | commitWalk;
    assign uncorrected = errValid & ~errCorrectable;
    // Speculative errors need action only when they surface as an abort
    assign needAct     = uncorrected & (consumed | errAbort);
    // Contained spread counts as not propagated only under the barrier conditions
    assign trulyUncontained = silentProp & ~containedProp;

    always_comb begin
        if (trulyUncontained || !containKnown) begin
            trueClass = CLASS_UNCONTAINABLE;
        end else if (consumed || imprecise) begin
            trueClass = CLASS_UNRECOVERABLE;
        end else if (needsRepair) begin
            trueClass = CLASS_RECOVERABLE;
        end else begin
            trueClass = CLASS_RESTARTABLE;
        end
    end

    // Upward only; saturates at uncontainable
    always_comb begin
        if (raiseFloor && trueClass != CLASS_UNCONTAINABLE) begin
            next_class = esc_class_e'(trueClass + 2'h1);
        end else begin
            next_class = trueClass;
        end
    end

    always_comb begin
        unique case (next_class)
            CLASS_UNCONTAINABLE: next_state = STATE_LOST;
            CLASS_UNRECOVERABLE: next_state = STATE_INFECTED;
            CLASS_RECOVERABLE:   next_state = STATE_LATENT;
            CLASS_RESTARTABLE:   next_state = STATE_PRESERVED;
        endcase
    end

    // Correction and logging path
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fixIrq   <= 1'b0;
            logValid <= 1'b0;
            logSrc   <= 2'h0;
        end else begin
            fixIrq   <= errValid & errCorrectable;
            logValid <= errValid & errCorrectable;
            if (errValid && errCorrectable) begin
                logSrc <= errSrc;
            end
        end
    end

    // Exception requests; a speculative-only abort never goes synchronous
    always_ff @(posedge core_clk) begin
        if (rst) begin
            excReq  <= 1'b0;
            serrReq <= 1'b0;
        end else begin
            excReq  <= needAct & canException & ~(errSpecOnly & ~consumed);
            serrReq <= needAct & canException & errSpecOnly & ~consumed;
        end
    end

    // Class registered beside the request so both land in one cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            excClass       <= 2'h0;
            excClassOneHot <= 4'h0;
            syndrome       <= SYN_RESET;
        end else if (needAct && canException) begin
            excClass       <= next_class;
            excClassOneHot <= 4'h1 << next_class;
            syndrome[SYN_SEV_LSB +: 2]   <= next_class;
            syndrome[SYN_STATE_LSB +: 2] <= next_state;
            syndrome[SYN_ASYNC_BIT]      <= errSpecOnly & ~consumed;
            syndrome[SYN_SRC_LSB +: 2]   <= errSrc;
        end
    end

    // No exception path: fall back to the failure mode, which is sticky
    always_ff @(posedge core_clk) begin
        if (rst) begin
            failMode <= 1'b0;
        end else if (needAct && !canException) begin
            failMode <= 1'b1;
        end
    end

    // Internal non-architectural nodes arrive asynchronously
    genvar gi;
    generate
        for (gi = 0; gi < NODE_COUNT; gi++) begin : gNode
            esc_sync_bit uSync (
                .core_clk (core_clk),
                .rst      (rst),
                .asyncIn  (nodeIrq[gi]),
                .syncOut  (nodeSync[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            recoveryIrq <= 1'b0;
        end else begin
            recoveryIrq <= |nodeSync;
        end
    end

    // Node status port answering one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sysRegValid <= 1'b0;
            sysRegData  <= 1'b0;
        end else begin
            sysRegValid <= sysRegRead;
            sysRegData  <= sysRegRead & nodeSync[sysRegSel];
        end
    end

    // Assertions
    AST_FIX_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        errValid && errCorrectable |=> fixIrq && logValid && !excReq)
        else $error("Correctable error did not raise fault interrupt");

    AST_EXC_ON_ABORT: assert property (@(posedge core_clk) disable iff (rst)
        uncorrected && errAbort && canException && !errSpecOnly |=> excReq)
        else $error("Uncorrected abort raised no exception");

    AST_SPEC_ASYNC: assert property (@(posedge core_clk) disable iff (rst)
        uncorrected && errAbort && errSpecOnly && !consumed && canException
        |=> serrReq && !excReq)
        else $error("Speculative abort not delivered as SError");

    AST_CONSUMED_ACT: assert property (@(posedge core_clk) disable iff (rst)
        uncorrected && (commitCorrupt || commitFetch || commitWalk)
        |=> (excReq || serrReq || failMode))
        else $error("Consumed error got no action");

    AST_UNCONTAINABLE_CLASS: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && ((silentProp && !containedProp) || !containKnown)
        |=> excClass == CLASS_UNCONTAINABLE)
        else $error("Propagated error not uncontainable");

    AST_UNRECOVERABLE_CLASS: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && !trulyUncontained && containKnown
        && (consumed || imprecise) |=> excClass >= CLASS_UNRECOVERABLE)
        else $error("Infected or imprecise error reported too low");

    AST_NEVER_LOWER: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException |=> excClass >= $past(trueClass))
        else $error("Severity reported below true class");

    AST_RESTART: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && trueClass == CLASS_RESTARTABLE && !raiseFloor
        |=> excClass == CLASS_RESTARTABLE)
        else $error("Restartable error misreported");

    AST_SYNDROME: assert property (@(posedge core_clk) disable iff (rst)
        excReq || serrReq |-> syndrome[SYN_SEV_LSB +: 2] == excClass
        && syndrome[SYN_STATE_LSB +: 2] == excClass)
        else $error("Syndrome severity differs from class");

    AST_ONEHOT: assert property (@(posedge core_clk) disable iff (rst)
        excReq |-> excClassOneHot == (4'h1 << excClass))
        else $error("One-hot class not aligned with request");

    AST_NODE_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        nodeIrq[0] [*4] |-> recoveryIrq)
        else $error("Node interrupt not forwarded");

    AST_RECOVERABLE_CLASS: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && !trulyUncontained && containKnown && !consumed
        && !imprecise && needsRepair && !raiseFloor |=> excClass == CLASS_RECOVERABLE)
        else $error("Repairable error misreported");

    // Spread confined to data registers after the exception or a barrier stays contained
    AST_CONTAINED_SPREAD: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && silentProp && containedProp && containKnown && !consumed
        && !imprecise && !needsRepair && !raiseFloor |=> excClass == CLASS_RESTARTABLE)
        else $error("Contained spread reported too severe");

    AST_UNKNOWN_CONTAIN: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && !containKnown |=> excClass == CLASS_UNCONTAINABLE)
        else $error("Undetermined containability not uncontainable");

    AST_CONSUMED_NO_ABORT: assert property (@(posedge core_clk) disable iff (rst)
        errValid && !errCorrectable && !errAbort && canException
        && (commitCorrupt || commitFetch || commitWalk) |=> excReq && !serrReq)
        else $error("Committed error without abort not acted on");

    AST_SPEC_COMMITTED: assert property (@(posedge core_clk) disable iff (rst)
        uncorrected && errSpecOnly && consumed && canException |=> excReq && !serrReq)
        else $error("Committed error delivered asynchronously");

    AST_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
        errValid && !errAbort && !consumed |=> !excReq && !serrReq)
        else $error("Exception raised without abort or consumption");

    AST_ONLY_UNCORRECTED: assert property (@(posedge core_clk) disable iff (rst)
        excReq || serrReq |-> $past(uncorrected))
        else $error("Exception raised for a corrected error");

    AST_LOG_SRC: assert property (@(posedge core_clk) disable iff (rst)
        errValid && errCorrectable |=> logSrc == $past(errSrc))
        else $error("Logged source differs from error source");

    AST_RAISE_ONE: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && raiseFloor && trueClass != CLASS_UNCONTAINABLE
        |=> excClass == $past(trueClass) + 2'h1)
        else $error("Raised severity not one class above");

    AST_IMPRECISE: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException && imprecise |=> excClass >= CLASS_UNRECOVERABLE)
        else $error("Imprecise exception reported too low");

    AST_FAIL_MODE: assert property (@(posedge core_clk) disable iff (rst)
        needAct && !canException |=> failMode && !excReq && !serrReq)
        else $error("No failure mode without exception path");

    AST_FAIL_STICKY: assert property (@(posedge core_clk) disable iff (rst)
        failMode |=> failMode)
        else $error("Failure mode left without reset");

    AST_ONE_REQUEST: assert property (@(posedge core_clk) disable iff (rst)
        !(excReq && serrReq))
        else $error("Synchronous and asynchronous request together");

    AST_ASYNC_FLAG: assert property (@(posedge core_clk) disable iff (rst)
        excReq || serrReq |-> syndrome[SYN_ASYNC_BIT] == serrReq)
        else $error("Syndrome async flag differs from request kind");

    AST_SYN_SRC: assert property (@(posedge core_clk) disable iff (rst)
        needAct && canException |=> syndrome[SYN_SRC_LSB +: 2] == $past(errSrc))
        else $error("Syndrome source differs from error source");

    AST_ONEHOT_VALID: assert property (@(posedge core_clk) disable iff (rst)
        excReq || serrReq |-> $onehot(excClassOneHot))
        else $error("One-hot class not one-hot");

    AST_CLASS_HELD: assert property (@(posedge core_clk) disable iff (rst)
        !(needAct && canException) |=> $stable(excClass) && $stable(syndrome))
        else $error("Class changed without a taken error");

    AST_SYSREG_ANSWER: assert property (@(posedge core_clk) disable iff (rst)
        sysRegRead |=> sysRegValid)
        else $error("System register read not answered");

    AST_SYSREG_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !sysRegRead |=> !sysRegValid && !sysRegData)
        else $error("System register answer without read");

    AST_NODE_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (!(|nodeIrq)) [*4] |-> !recoveryIrq)
        else $error("Recovery interrupt without node request");

endmodule : esc_classifier

// ### common/esc_pkg.sv
// Package for the error severity classifier: classes, sources and timing constants
package esc_pkg;

    // Reported error severity, also the syndrome severity field
    typedef enum logic [1:0] {
        CLASS_RESTARTABLE    = 2'h0,
        CLASS_RECOVERABLE    = 2'h1,
        CLASS_UNRECOVERABLE  = 2'h2,
        CLASS_UNCONTAINABLE  = 2'h3
    } esc_class_e;

    // Kind of access on which the error arrived
    typedef enum logic [1:0] {
        SRC_READ  = 2'h0,
        SRC_WRITE = 2'h1,
        SRC_CMO   = 2'h2,
        SRC_FETCH = 2'h3
    } esc_src_e;

    // Processing element state class written beside the severity
    typedef enum logic [1:0] {
        STATE_PRESERVED = 2'h0,
        STATE_LATENT    = 2'h1,
        STATE_INFECTED  = 2'h2,
        STATE_LOST      = 2'h3
    } esc_state_e;

    localparam int          SYN_SEV_LSB     = 0;
    localparam int          SYN_STATE_LSB   = 2;
    localparam int          SYN_ASYNC_BIT   = 4;
    localparam int          SYN_SRC_LSB     = 5;
    localparam int          SYN_W           = 7;
    localparam logic [6:0]  SYN_RESET       = 7'h00;
    localparam int          NODE_W          = 3;
    localparam logic [2:0]  NODE_RESET      = 3'h0;
    localparam int          NODE_COUNT      = 8;
    localparam logic [7:0]  NODE_REG_RESET  = 8'h00;
    localparam int          SYNC_STAGES     = 2;

endpackage : esc_pkg

// ### hdl/esc_sync_bit.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module esc_sync_bit
    import esc_pkg::*;
(
    input  wire logic core_clk,   // Core clock
    input  wire logic rst,        // Synchronous reset, active high
    input  wire logic asyncIn,    // Level from another domain
    output logic      syncOut     // Level safe to read in core_clk
);
    logic stage1;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule : esc_sync_bit

// ### testbench/esc_node_model.sv
// Model of the error-detecting nodes that raise recovery interrupts
`timescale 1ns/100ps
module esc_node_model
    import esc_pkg::*;
(
    input  wire logic                  core_clk,  // Core clock
    input  wire logic                  rst,       // Synchronous reset, active high
    input  wire logic [NODE_COUNT-1:0] faultSet,  // Nodes that detect a fault now
    input  wire logic [NODE_COUNT-1:0] faultClr,  // Nodes whose fault was serviced
    output logic      [NODE_COUNT-1:0] nodeIrq    // Recovery interrupt levels
);
    // A node keeps its interrupt up until serviced, as a real error record would
    always_ff @(posedge core_clk) begin
        if (rst) begin
            nodeIrq <= NODE_REG_RESET;
        end else begin
            nodeIrq <= (nodeIrq & ~faultClr) | faultSet;
        end
    end
endmodule : esc_node_model

// ### testbench/testbench.sv
// Self-checking bench for the error severity classifier
`timescale 1ns/100ps
`define ESC_CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin errorCnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module testbench
    import esc_pkg::*;
;
    typedef struct packed {
        logic v, corr, abrt; logic [1:0] src; logic spec, cCor, cFet, cWalk;
        logic silent, contained, known, impr, repair, canExc, raise;
    } esc_stim_s;
    logic core_clk = 1'b0, rst = 1'b1, errValid = 1'b0, errCorrectable = 1'b0;
    logic errAbort = 1'b0, errSpecOnly = 1'b0, commitCorrupt = 1'b0, commitFetch = 1'b0;
    logic commitWalk = 1'b0, silentProp = 1'b0, containedProp = 1'b0, containKnown = 1'b0;
    logic imprecise = 1'b0, needsRepair = 1'b0, canException = 1'b0, raiseFloor = 1'b0;
    logic sysRegRead = 1'b0, fixIrq, excReq, serrReq, failMode, logValid;
    logic recoveryIrq, sysRegValid, sysRegData;
    logic [1:0] errSrc = 2'h0, excClass, logSrc;
    logic [3:0] excClassOneHot;
    logic [SYN_W-1:0] syndrome;
    logic [NODE_W-1:0] sysRegSel = 3'h0;
    logic [NODE_COUNT-1:0] nodeIrq, faultSet = 8'h00, faultClr = 8'h00;
    int errorCnt = 0, checksDone = 0, cycles = 0;
    logic failExp = 1'b0;
    logic [15:0] lfsr = 16'h0014;
    esc_stim_s cur = '0, prev;

    always #5 core_clk = ~core_clk;

    esc_classifier dut (.core_clk(core_clk), .rst(rst), .errValid(errValid),
        .errCorrectable(errCorrectable), .errAbort(errAbort), .errSrc(errSrc),
        .errSpecOnly(errSpecOnly), .commitCorrupt(commitCorrupt), .commitFetch(commitFetch),
        .commitWalk(commitWalk), .silentProp(silentProp), .containedProp(containedProp),
        .containKnown(containKnown), .imprecise(imprecise), .needsRepair(needsRepair),
        .canException(canException), .raiseFloor(raiseFloor), .nodeIrq(nodeIrq),
        .sysRegRead(sysRegRead), .sysRegSel(sysRegSel), .fixIrq(fixIrq), .excReq(excReq),
        .serrReq(serrReq), .excClass(excClass), .excClassOneHot(excClassOneHot),
        .syndrome(syndrome), .failMode(failMode), .logValid(logValid), .logSrc(logSrc),
        .recoveryIrq(recoveryIrq), .sysRegValid(sysRegValid), .sysRegData(sysRegData));
    esc_node_model nodes (.core_clk(core_clk), .rst(rst), .faultSet(faultSet),
        .faultClr(faultClr), .nodeIrq(nodeIrq));

    function automatic logic [15:0] esc_lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : esc_lfsr

    function automatic logic [1:0] esc_exp_class(input esc_stim_s s);
        logic [1:0] c;
        if ((s.silent && !s.contained) || !s.known) c = 2'h3;
        else if (s.cCor || s.cFet || s.cWalk || s.impr) c = 2'h2;
        else if (s.repair) c = 2'h1;
        else c = 2'h0;
        if (s.raise && c != 2'h3) c = c + 2'h1;
        return c;
    endfunction : esc_exp_class

    task automatic end_sim();
        $display("Checks done %0d, mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // Inputs go out on one edge; the answer to the previous set is checked mid-cycle
    task automatic step(input esc_stim_s s);
        logic cons, act, sp;
        logic [1:0] ec;
        @(posedge core_clk);
        {errValid, errCorrectable, errAbort, errSrc, errSpecOnly, commitCorrupt, commitFetch,
            commitWalk, silentProp, containedProp, containKnown, imprecise, needsRepair,
            canException, raiseFloor} <= s;
        prev = cur;
        cur = s;
        @(negedge core_clk);
        cons = prev.cCor || prev.cFet || prev.cWalk;
        act = prev.v && !prev.corr && (cons || prev.abrt);
        sp = prev.spec && !cons;
        ec = esc_exp_class(prev);
        failExp = failExp | (act && !prev.canExc);
        `ESC_CHK("fixIrq", prev.v && prev.corr, fixIrq)
        `ESC_CHK("logValid", prev.v && prev.corr, logValid)
        if (prev.v && prev.corr) `ESC_CHK("logSrc", prev.src, logSrc)
        `ESC_CHK("excReq", act && prev.canExc && !sp, excReq)
        `ESC_CHK("serrReq", act && prev.canExc && sp, serrReq)
        `ESC_CHK("failMode", failExp, failMode)
        if (act && prev.canExc) begin
            `ESC_CHK("excClass", ec, excClass)
            `ESC_CHK("excClassOneHot", 4'h1 << ec, excClassOneHot)
            // State class follows severity one to one
            `ESC_CHK("syndrome", {prev.src, sp, ec, ec}, syndrome)
        end
    endtask : step

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            end_sim();
        end
    end

    initial begin
        esc_stim_s corner [12];
        logic [15:0] r;
        corner = '{16'hebfe, 16'ha012, 16'ha816, 16'hb01a, 16'h9a12, 16'ha052,
            16'ha072, 16'ha073, 16'ha402, 16'ha612, 16'h8093, 16'h8110};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        foreach (corner[i]) step(corner[i]);
        repeat (400) begin
            // Sixteen shifts per draw so the two words share no bits
            repeat (16) lfsr = esc_lfsr(lfsr);
            r = lfsr;
            repeat (16) lfsr = esc_lfsr(lfsr);
            step({r[6] | r[7], r[8] & r[9], r[10], r[12:11], lfsr[0], lfsr[1] & r[13],
                lfsr[2] & r[14], lfsr[3] & r[15], lfsr[4], lfsr[5], |r[2:0], lfsr[6],
                lfsr[7], |r[5:3], lfsr[8]});
        end
        step('0);
        @(posedge core_clk);
        faultSet <= 8'ha5;
        @(posedge core_clk);
        faultSet <= 8'h00;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        `ESC_CHK("recoveryIrq", 1'b1, recoveryIrq)
        for (int i = 0; i <= NODE_COUNT; i++) begin
            @(posedge core_clk);
            sysRegRead <= (i < NODE_COUNT);
            sysRegSel <= NODE_W'(i);
            @(negedge core_clk);
            if (i > 0) `ESC_CHK("sysRegData", 8'ha5 >> (i - 1) & 8'h01, 8'(sysRegData))
            if (i > 0) `ESC_CHK("sysRegValid", 1'b1, sysRegValid)
        end
        @(posedge core_clk);
        faultClr <= 8'hff;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `ESC_CHK("failMode", 1'b0, failMode)
        `ESC_CHK("recoveryIrq", 1'b0, recoveryIrq)
        // A second release must leave everything quiet and take a fresh error
        @(posedge core_clk);
        rst <= 1'b0;
        faultClr <= 8'h00;
        failExp = 1'b0;
        step(corner[1]);
        step('0);
        end_sim();
    end
endmodule : testbench
